// File: hdl/rrs_pkg.sv
// Behaviour
// - Unconditional pop jump: 10 states, 4,3,3.
// - Taken conditional pop: low byte, then high.
// - Untaken condition: no stack access, next instruction.
// - Condition field selects Z, C, P/V, S polarity.
// - Taken conditional pop: 11 states, 5,3,3.
// - Untaken conditional pop: one cycle, 5 states.
// - Return instructions never alter condition flags.
// - Maskable exit pops counter like plain pop.
// - Maskable exit completion is visible to peripherals.
// - Maskable exit leaves enable latch unchanged.
// - Both service exits: 14 states, 4,4,3,3.
// - Non-maskable exit copies shadow into enable latch.
// - Non-maskable entry pushes counter, jumps to 0066H.
// - Restart pushes high byte then low byte.
// - Restart target: high zero, low field times eight.
// - Restart: 11 states, 5,3,3.
package rrs_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0]  RRS_OFS_CMD        = 8'h00;
    localparam logic [7:0]  RRS_OFS_PC         = 8'h04;
    localparam logic [7:0]  RRS_OFS_SP         = 8'h08;
    localparam logic [7:0]  RRS_OFS_FLAGS      = 8'h0c;
    localparam logic [7:0]  RRS_OFS_IFF        = 8'h10;
    localparam logic [7:0]  RRS_OFS_STATUS     = 8'h14;

    // Field positions.
    localparam int          RRS_CMD_PREFIX_BIT = 8;
    localparam int          RRS_CMD_NMI_BIT    = 9;
    localparam int          RRS_FLG_S_BIT      = 7;
    localparam int          RRS_FLG_Z_BIT      = 6;
    localparam int          RRS_FLG_PV_BIT     = 2;
    localparam int          RRS_FLG_C_BIT      = 0;
    localparam int          RRS_IFF_LATCH_BIT  = 0;
    localparam int          RRS_IFF_SHADOW_BIT = 1;
    localparam int          RRS_STS_BUSY_BIT   = 0;
    localparam int          RRS_STS_TAKEN_BIT  = 1;
    localparam int          RRS_STS_BADOP_BIT  = 2;
    localparam int          RRS_STS_EXIT_BIT   = 3;

    // Reset values.
    localparam logic [15:0] RRS_PC_RST         = 16'h0000;
    localparam logic [15:0] RRS_SP_RST         = 16'h0000;
    localparam logic [7:0]  RRS_FLAGS_RST      = 8'h00;

    // Clock states per sequencer step, one machine cycle except the prefixed fetch, which spans two; one clock is one state.
    localparam logic [3:0]  RRS_T_RET_FETCH    = 4'h4;
    localparam logic [3:0]  RRS_T_CC_FETCH     = 4'h5;
    localparam logic [3:0]  RRS_T_ED_FETCH     = 4'h8;
    localparam logic [3:0]  RRS_T_RST_FETCH    = 4'h5;
    localparam logic [3:0]  RRS_T_NMI_FETCH    = 4'h5;
    localparam logic [3:0]  RRS_T_MEM          = 4'h3;

    // Opcodes and vectors.
    localparam logic [7:0]  RRS_OPC_RET        = 8'hc9;
    localparam logic [7:0]  RRS_OPC_FIELD_MASK = 8'hc7;
    localparam logic [7:0]  RRS_OPC_RETCC      = 8'hc0;
    localparam logic [7:0]  RRS_OPC_RST        = 8'hc7;
    localparam logic [7:0]  RRS_OPC_PREFIX     = 8'hed;
    localparam logic [7:0]  RRS_OPC_MASKABLE_SERVICE_EXIT       = 8'h4d;
    localparam logic [7:0]  RRS_OPC_NONMASKABLE_SERVICE_EXIT       = 8'h45;
    localparam logic [15:0] RRS_NMI_VECTOR     = 16'h0066;

    typedef enum logic [5:0] {
        RRS_ST_IDLE   = 6'b000001,
        RRS_ST_FETCH  = 6'b000010,
        RRS_ST_RD_LO  = 6'b000100,
        RRS_ST_RD_HI  = 6'b001000,
        RRS_ST_WR_HI  = 6'b010000,
        RRS_ST_WR_LO  = 6'b100000
    } rrs_state_type;

    typedef enum logic [5:0] {
        RRS_OP_RET    = 6'b000001,
        RRS_OP_RETCC  = 6'b000010,
        RRS_OP_MASKABLE_SERVICE_EXIT   = 6'b000100,
        RRS_OP_NONMASKABLE_SERVICE_EXIT   = 6'b001000,
        RRS_OP_RST    = 6'b010000,
        RRS_OP_NMI    = 6'b100000
    } rrs_op_type;

endpackage : rrs_pkg

// File: hdl/rrs_sync2.sv
`timescale 1ns/1ps
module rrs_sync2 #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Data.
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= '0;
            q_o    <= '0;
        end else begin
            stage1 <= d_i;
            q_o    <= stage1;
        end
    end

endmodule : rrs_sync2

// File: hdl/rrs_return_restart_sequencer.sv
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module rrs_return_restart_sequencer
    import rrs_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Avalon-MM register slave.
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Stack memory.
    output logic      [15:0] mem_addr_o,
    output logic             mem_rd_o,
    output logic             mem_wr_o,
    output logic      [7:0]  mem_wdata_o,
    input  wire logic [7:0]  mem_rdata_i,
    // Status towards the system.
    output logic             svc_exit_o,
    output logic             done_o,
    output logic             interrupt_enable_latch_o
);

    typedef struct packed {
        rrs_state_type state;
        rrs_op_type    op;
        logic [2:0]    field;
        logic [3:0]    tlen;
        logic [3:0]    tcnt;
        logic [15:0]   pc;
        logic [15:0]   sp;
        logic [7:0]    flags;
        logic          iff_latch;
        logic          iff_shadow;
        logic          cond_taken;
        logic          bad_op;
        logic          exit_seen;
        logic          mem_rd;
        logic          mem_wr;
        logic [15:0]   mem_addr;
        logic [7:0]    mem_wdata;
        logic          done;
        logic          svc_exit;
        logic          rd_pend;
        logic [31:0]   readdata;
    } rrs_regs_type;

    rrs_regs_type r;
    rrs_regs_type next_r;

    logic [7:0]   rdata_sync;
    logic         busy;
    logic         wr_ok;
    logic         step_end;
    logic [31:0]  wmerge;
    logic [7:0]   opc;

    // Memory data arrive from pins, so they are resynchronised. The read cycle
    // is three states long, which leaves exactly the two stages of latency.
    rrs_sync2 #(
        .WIDTH (8)
    ) u_rdata_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (mem_rdata_i),
        .q_o     (rdata_sync)
    );

    function automatic logic [31:0] rrs_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : rrs_merge

    // Condition field: upper two bits pick the flag, low bit its polarity.
    function automatic logic rrs_cond(
        input logic [2:0] ccc,
        input logic [7:0] flags
    );
        logic f;
        f = 1'b0;
        case (ccc[2:1])
            2'b00:   f = flags[RRS_FLG_Z_BIT];
            2'b01:   f = flags[RRS_FLG_C_BIT];
            2'b10:   f = flags[RRS_FLG_PV_BIT];
            default: f = flags[RRS_FLG_S_BIT];
        endcase
        return f == ccc[0];
    endfunction : rrs_cond

    assign busy      = (r.state != RRS_ST_IDLE);
    // Writes wait while an instruction runs, so software never races the
    // sequencer on the counter, stack pointer or enable bits.
    assign wr_ok     = avs_write_i && !busy;
    assign step_end  = (r.tcnt == r.tlen - 4'h1);
    assign opc       = avs_writedata_i[7:0];

    assign avs_waitrequest_o        = (avs_write_i && busy) || (avs_read_i && !r.rd_pend);
    assign avs_readdata_o           = r.readdata;
    assign mem_addr_o               = r.mem_addr;
    assign mem_rd_o                 = r.mem_rd;
    assign mem_wr_o                 = r.mem_wr;
    assign mem_wdata_o              = r.mem_wdata;
    assign svc_exit_o               = r.svc_exit;
    assign done_o                   = r.done;
    assign interrupt_enable_latch_o = r.iff_latch;

    always_comb begin
        next_r          = r;
        next_r.done     = 1'b0;
        next_r.svc_exit = 1'b0;
        wmerge          = 32'h0000_0000;

        // Reads take one wait state; the word is captured on the first cycle.
        next_r.rd_pend = avs_read_i && !r.rd_pend;
        if (avs_read_i && !r.rd_pend) begin
            if (avs_address_i == RRS_OFS_PC) begin
                next_r.readdata = {16'h0000, r.pc};
            end else if (avs_address_i == RRS_OFS_SP) begin
                next_r.readdata = {16'h0000, r.sp};
            end else if (avs_address_i == RRS_OFS_FLAGS) begin
                next_r.readdata = {24'h000000, r.flags};
            end else if (avs_address_i == RRS_OFS_IFF) begin
                next_r.readdata = {30'h0, r.iff_shadow, r.iff_latch};
            end else if (avs_address_i == RRS_OFS_STATUS) begin
                next_r.readdata = {28'h0000000, r.exit_seen, r.bad_op, r.cond_taken, busy};
            end else begin
                next_r.readdata = 32'h0000_0000;
            end
        end

        // Software writes, only accepted while idle.
        if (wr_ok) begin
            if (avs_address_i == RRS_OFS_PC) begin
                wmerge    = rrs_merge({16'h0000, r.pc}, avs_writedata_i, avs_byteenable_i);
                next_r.pc = wmerge[15:0];
            end else if (avs_address_i == RRS_OFS_SP) begin
                wmerge    = rrs_merge({16'h0000, r.sp}, avs_writedata_i, avs_byteenable_i);
                next_r.sp = wmerge[15:0];
            end else if (avs_address_i == RRS_OFS_FLAGS) begin
                if (avs_byteenable_i[0]) begin
                    next_r.flags = avs_writedata_i[7:0];
                end
            end else if (avs_address_i == RRS_OFS_IFF) begin
                if (avs_byteenable_i[0]) begin
                    next_r.iff_latch  = avs_writedata_i[RRS_IFF_LATCH_BIT];
                    next_r.iff_shadow = avs_writedata_i[RRS_IFF_SHADOW_BIT];
                end
            end else if (avs_address_i == RRS_OFS_STATUS) begin
                if (avs_byteenable_i[0] && avs_writedata_i[RRS_STS_BADOP_BIT]) begin
                    next_r.bad_op = 1'b0;
                end
                if (avs_byteenable_i[0] && avs_writedata_i[RRS_STS_EXIT_BIT]) begin
                    next_r.exit_seen = 1'b0;
                end
            end else if (avs_address_i == RRS_OFS_CMD) begin
                next_r.tcnt = 4'h0;
                next_r.state = RRS_ST_FETCH;
                next_r.field = opc[5:3];
                if (avs_writedata_i[RRS_CMD_NMI_BIT]) begin
                    next_r.op   = RRS_OP_NMI;
                    next_r.tlen = RRS_T_NMI_FETCH;
                end else if (avs_writedata_i[RRS_CMD_PREFIX_BIT]) begin
                    next_r.tlen = RRS_T_ED_FETCH;
                    if (opc == RRS_OPC_MASKABLE_SERVICE_EXIT) begin
                        next_r.op = RRS_OP_MASKABLE_SERVICE_EXIT;
                    end else if (opc == RRS_OPC_NONMASKABLE_SERVICE_EXIT) begin
                        next_r.op = RRS_OP_NONMASKABLE_SERVICE_EXIT;
                    end else begin
                        next_r.state  = RRS_ST_IDLE;
                        next_r.bad_op = 1'b1;
                    end
                end else if (opc == RRS_OPC_RET) begin
                    next_r.op   = RRS_OP_RET;
                    next_r.tlen = RRS_T_RET_FETCH;
                end else if ((opc & RRS_OPC_FIELD_MASK) == RRS_OPC_RETCC) begin
                    next_r.op   = RRS_OP_RETCC;
                    next_r.tlen = RRS_T_CC_FETCH;
                end else if ((opc & RRS_OPC_FIELD_MASK) == RRS_OPC_RST) begin
                    next_r.op   = RRS_OP_RST;
                    next_r.tlen = RRS_T_RST_FETCH;
                end else begin
                    next_r.state  = RRS_ST_IDLE;
                    next_r.bad_op = 1'b1;
                end
            end
        end

        // Sequencer. Flags are never written here, only by software.
        case (r.state)
            RRS_ST_IDLE: begin
                next_r.mem_rd = 1'b0;
                next_r.mem_wr = 1'b0;
            end
            RRS_ST_FETCH: begin
                next_r.tcnt = r.tcnt + 4'h1;
                if (step_end) begin
                    next_r.tcnt = 4'h0;
                    next_r.tlen = RRS_T_MEM;
                    case (r.op)
                        RRS_OP_RETCC: begin
                            if (rrs_cond(r.field, r.flags)) begin
                                next_r.cond_taken = 1'b1;
                                next_r.state      = RRS_ST_RD_LO;
                                next_r.mem_rd     = 1'b1;
                                next_r.mem_addr   = r.sp;
                            end else begin
                                // No stack cycle; just step past the opcode.
                                next_r.cond_taken = 1'b0;
                                next_r.pc         = r.pc + 16'h0001;
                                next_r.state      = RRS_ST_IDLE;
                                next_r.done       = 1'b1;
                            end
                        end
                        RRS_OP_RST: begin
                            next_r.pc        = r.pc + 16'h0001;
                            next_r.sp        = r.sp - 16'h0001;
                            next_r.mem_addr  = r.sp - 16'h0001;
                            next_r.mem_wdata = next_r.pc[15:8];
                            next_r.mem_wr    = 1'b1;
                            next_r.state     = RRS_ST_WR_HI;
                        end
                        RRS_OP_NMI: begin
                            // The interrupted instruction is not stepped past: the
                            // counter is pushed as it stands.
                            next_r.sp         = r.sp - 16'h0001;
                            next_r.mem_addr   = r.sp - 16'h0001;
                            next_r.mem_wdata  = r.pc[15:8];
                            next_r.mem_wr     = 1'b1;
                            next_r.iff_shadow = r.iff_latch;
                            next_r.iff_latch  = 1'b0;
                            next_r.state      = RRS_ST_WR_HI;
                        end
                        default: begin
                            // Plain pop and both service exits share the pop.
                            next_r.state    = RRS_ST_RD_LO;
                            next_r.mem_rd   = 1'b1;
                            next_r.mem_addr = r.sp;
                        end
                    endcase
                end
            end
            RRS_ST_RD_LO: begin
                next_r.tcnt = r.tcnt + 4'h1;
                if (step_end) begin
                    next_r.tcnt     = 4'h0;
                    next_r.pc       = {r.pc[15:8], rdata_sync};
                    next_r.sp       = r.sp + 16'h0001;
                    next_r.mem_addr = r.sp + 16'h0001;
                    next_r.state    = RRS_ST_RD_HI;
                end
            end
            RRS_ST_RD_HI: begin
                next_r.tcnt = r.tcnt + 4'h1;
                if (step_end) begin
                    next_r.tcnt   = 4'h0;
                    next_r.pc     = {rdata_sync, r.pc[7:0]};
                    next_r.sp     = r.sp + 16'h0001;
                    next_r.mem_rd = 1'b0;
                    next_r.state  = RRS_ST_IDLE;
                    next_r.done   = 1'b1;
                    if (r.op == RRS_OP_NONMASKABLE_SERVICE_EXIT) begin
                        next_r.iff_latch = r.iff_shadow;
                    end
                    if (r.op == RRS_OP_MASKABLE_SERVICE_EXIT) begin
                        // The enable latch is left alone here.
                        next_r.svc_exit  = 1'b1;
                        next_r.exit_seen = 1'b1;
                    end
                end
            end
            RRS_ST_WR_HI: begin
                next_r.tcnt = r.tcnt + 4'h1;
                if (step_end) begin
                    next_r.tcnt      = 4'h0;
                    next_r.sp        = r.sp - 16'h0001;
                    next_r.mem_addr  = r.sp - 16'h0001;
                    next_r.mem_wdata = r.pc[7:0];
                    next_r.state     = RRS_ST_WR_LO;
                end
            end
            RRS_ST_WR_LO: begin
                next_r.tcnt = r.tcnt + 4'h1;
                if (step_end) begin
                    next_r.tcnt   = 4'h0;
                    next_r.mem_wr = 1'b0;
                    next_r.state  = RRS_ST_IDLE;
                    next_r.done   = 1'b1;
                    if (r.op == RRS_OP_RST) begin
                        next_r.pc = {8'h00, 2'b00, r.field, 3'b000};
                    end else begin
                        next_r.pc = RRS_NMI_VECTOR;
                    end
                end
            end
            default: begin
                next_r.state  = RRS_ST_IDLE;
                next_r.mem_rd = 1'b0;
                next_r.mem_wr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r       <= '0;
            r.state <= RRS_ST_IDLE;
            r.op    <= RRS_OP_RET;
            r.pc    <= RRS_PC_RST;
            r.sp    <= RRS_SP_RST;
            r.flags <= RRS_FLAGS_RST;
        end else begin
            r <= next_r;
        end
    end

endmodule : rrs_return_restart_sequencer

// File: verif/rrs_stack_mem.sv
`timescale 1ns/1ps
module rrs_stack_mem (
    // Clock.
    input  wire logic        clk_i,
    // Stack memory bus.
    input  wire logic [15:0] mem_addr_i,
    input  wire logic        mem_rd_i,
    input  wire logic        mem_wr_i,
    input  wire logic [7:0]  mem_wdata_i,
    output logic      [7:0]  mem_rdata_o,
    // Daisy-chained peripheral.
    input  wire logic        ack_i,
    input  wire logic        svc_exit_i,
    output logic             chain_enable_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last;

    initial begin
        last = 8'h5a;
        chain_enable_o = 1'b1;
    end

    // Outside a pop the data lines float; a changing pattern exposes a stale capture.
    assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last;

    always @(posedge clk_i) begin
        last <= mem_rdata_o;
        if (mem_wr_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
        if (ack_i) begin
            chain_enable_o <= 1'b0;
        end else if (svc_exit_i) begin
            chain_enable_o <= 1'b1;
        end
    end
endmodule : rrs_stack_mem

// File: verif/rrs_return_restart_sequencer_asserts.sv
`timescale 1ns/1ps
module rrs_return_restart_sequencer_asserts (
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // Watched outputs.
    input wire logic [15:0] mem_addr_o,
    input wire logic        mem_rd_o,
    input wire logic        mem_wr_o,
    input wire logic        svc_exit_o,
    input wire logic        done_o,
    input wire logic        interrupt_enable_latch_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_svc_done;
        svc_exit_o |-> done_o;
    endproperty
    a_svc_done: assert property (p_svc_done) else $error("exit pulse without completion");
    property p_pop_len;
        $rose(mem_rd_o) |-> mem_rd_o [*6] ##1 (!mem_rd_o && done_o);
    endproperty
    a_pop_len: assert property (p_pop_len) else $error("pop length wrong");
    property p_push_len;
        $rose(mem_wr_o) |-> mem_wr_o [*6] ##1 (!mem_wr_o && done_o);
    endproperty
    a_push_len: assert property (p_push_len) else $error("push length wrong");
    property p_pop_addr;
        $rose(mem_rd_o) |-> ##3 (mem_addr_o == $past(mem_addr_o, 3) + 16'h0001);
    endproperty
    a_pop_addr: assert property (p_pop_addr) else $error("pop address order wrong");
    property p_push_addr;
        $rose(mem_wr_o) |-> ##3 (mem_addr_o == $past(mem_addr_o, 3) - 16'h0001);
    endproperty
    a_push_addr: assert property (p_push_addr) else $error("push address order wrong");
    property p_svc_latch;
        svc_exit_o |-> $stable(interrupt_enable_latch_o);
    endproperty
    a_svc_latch: assert property (p_svc_latch) else $error("enable latch changed on exit");
    property p_svc_len;
        svc_exit_o |-> $past(mem_rd_o, 6) && !$past(mem_rd_o, 7);
    endproperty
    a_svc_len: assert property (p_svc_len) else $error("service exit length wrong");
    property p_done_pulse;
        done_o |=> !done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("completion held too long");
endmodule : rrs_return_restart_sequencer_asserts

// File: verif/rrs_return_restart_sequencer_tb_top.sv
`timescale 1ns/1ps
module rrs_return_restart_sequencer_tb_top;
    import rrs_pkg::*;

    typedef struct {
        logic [9:0]  cmd;
        logic [7:0]  flags;
        logic [1:0]  iff_in;
        logic [1:0]  iff_out;
        int          cyc;
        int          rd;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] push;
    } rrs_row_type;

    logic        clk_i;
    logic        rst_n_i;
    logic [7:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [15:0] mem_addr_o;
    logic        mem_rd_o;
    logic        mem_wr_o;
    logic [7:0]  mem_wdata_o;
    logic [7:0]  mem_rdata_i;
    logic        svc_exit_o;
    logic        done_o;
    logic        latch_o;
    logic        ack;
    logic        chain;
    logic [31:0] q;
    int          n_errors;
    int          comparisons;
    rrs_row_type rows [28];

    rrs_return_restart_sequencer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i), .svc_exit_o(svc_exit_o), .done_o(done_o),
        .interrupt_enable_latch_o(latch_o));

    rrs_stack_mem u_mem (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .ack_i(ack), .svc_exit_i(svc_exit_o),
        .chain_enable_o(chain));

    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low; the watchdog bounds the wait.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        avs_writedata_i <= d;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask : bus

    function automatic rrs_row_type cond_row(int i, logic [7:0] f, bit t);
        cond_row = '{10'h0c0 | 10'(i * 8), f, 2'b00, 2'b00, t ? 11 : 5, t ? 6 : 0,
                     t ? 16'h18b5 : 16'h3536, t ? 16'h2002 : 16'h2000, 16'h0000};
    endfunction : cond_row

    task automatic run_row(input rrs_row_type r);
        int n;
        int nrd;
        n = 0;
        nrd = 0;
        u_mem.mem[16'h1fff] = 8'h00;
        u_mem.mem[16'h1ffe] = 8'h00;
        bus(1'b1, RRS_OFS_PC, 32'h3535);
        bus(1'b1, RRS_OFS_SP, 32'h2000);
        bus(1'b1, RRS_OFS_FLAGS, {24'h0, r.flags});
        bus(1'b1, RRS_OFS_IFF, {30'h0, r.iff_in});
        bus(1'b1, RRS_OFS_CMD, {22'h0, r.cmd});
        do begin
            @(posedge clk_i);
            #1;
            n++;
            if (mem_rd_o === 1'b1) nrd++;
        end while (done_o !== 1'b1 && n < 40);
        chk(32'(n), 32'(r.cyc));
        chk(32'(nrd), 32'(r.rd));
        bus(1'b0, RRS_OFS_PC, 32'h0);
        chk({16'h0, q[15:0]}, {16'h0, r.pc});
        bus(1'b0, RRS_OFS_SP, 32'h0);
        chk({16'h0, q[15:0]}, {16'h0, r.sp});
        bus(1'b0, RRS_OFS_FLAGS, 32'h0);
        chk({24'h0, q[7:0]}, {24'h0, r.flags});
        bus(1'b0, RRS_OFS_IFF, 32'h0);
        chk({30'h0, q[1:0]}, {30'h0, r.iff_out});
        chk({31'h0, latch_o}, {31'h0, r.iff_out[0]});
        if ((r.cmd[7:0] & RRS_OPC_FIELD_MASK) == RRS_OPC_RETCC) begin
            bus(1'b0, RRS_OFS_STATUS, 32'h0);
            chk({31'h0, q[RRS_STS_TAKEN_BIT]}, {31'h0, r.rd != 0});
        end
        if (r.push != 16'h0000) begin
            chk({u_mem.mem[16'h1fff], u_mem.mem[16'h1ffe]}, r.push);
        end
    endtask : run_row

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        #500000;
        n_errors++;
        stop_test();
    end

    initial begin
        n_errors = 0;
        comparisons = 0;
        rst_n_i = 1'b0;
        avs_address_i = 8'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        ack = 1'b0;
        u_mem.mem[16'h2000] = 8'hb5;
        u_mem.mem[16'h2001] = 8'h18;
        rows[0] = '{10'h0c9, 8'h00, 2'b00, 2'b00, 10, 6, 16'h18b5, 16'h2002, 16'h0000};
        rows[1] = '{10'h14d, 8'hc5, 2'b10, 2'b10, 14, 6, 16'h18b5, 16'h2002, 16'h0000};
        rows[2] = '{10'h145, 8'h00, 2'b10, 2'b11, 14, 6, 16'h18b5, 16'h2002, 16'h0000};
        rows[3] = '{10'h200, 8'hc5, 2'b01, 2'b10, 11, 0, 16'h0066, 16'h1ffe, 16'h3535};
        for (int i = 0; i < 8; i++) begin
            rows[4 + i] = cond_row(i, 8'h00, i % 2 == 0);
            rows[12 + i] = cond_row(i, 8'hc5, i % 2 == 1);
            rows[20 + i] = '{10'h0c7 | 10'(i * 8), 8'h00, 2'b00, 2'b00, 11, 0, 16'(i * 8), 16'h1ffe, 16'h3536};
        end
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        @(posedge clk_i);
        ack <= 1'b1;
        @(posedge clk_i);
        ack <= 1'b0;
        @(negedge clk_i);
        chk({31'h0, chain}, 32'h0);
        run_row(rows[1]);
        chk({31'h0, chain}, 32'h1);
        // Undefined commands must be flagged, plain and prefixed alike.
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, RRS_OFS_CMD, k == 0 ? 32'h000 : 32'h144);
            bus(1'b0, RRS_OFS_STATUS, 32'h0);
            chk({28'h0, q[3:2], 1'b0, q[0]}, 32'hc);
            bus(1'b1, RRS_OFS_STATUS, 32'h4);
        end
        bus(1'b1, RRS_OFS_STATUS, 32'h8);
        bus(1'b0, RRS_OFS_STATUS, 32'h0);
        chk({28'h0, q[3:2], 2'b00}, 32'h0);
        bus(1'b1, RRS_OFS_SP, 32'h2000);
        bus(1'b1, RRS_OFS_CMD, 32'h0c9);
        bus(1'b0, RRS_OFS_STATUS, 32'h0);
        chk({31'h0, q[RRS_STS_BUSY_BIT]}, 32'h1);
        bus(1'b1, RRS_OFS_PC, 32'h1234);
        bus(1'b0, RRS_OFS_PC, 32'h0);
        chk({16'h0, q[15:0]}, 32'h1234);
        bus(1'b1, 8'h20, 32'hffff_ffff);
        bus(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        // A reset in mid-instruction must clear the counter, stack pointer, flags and enable bits.
        bus(1'b1, RRS_OFS_CMD, 32'h0c9);
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int a = 4; a <= 16; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            chk(q, 32'h0);
        end
        stop_test();
    end
endmodule : rrs_return_restart_sequencer_tb_top

bind rrs_return_restart_sequencer rrs_return_restart_sequencer_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .svc_exit_o(svc_exit_o),
    .done_o(done_o), .interrupt_enable_latch_o(interrupt_enable_latch_o));
